// ===== rtl/microprogram_sequencer.sv
// microprogram sequencer: program counter, return stack, test register, apb view
// assumes pins synchronous to pclk; control memory and microinstruction register outside
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "seq_defines.svh"

// What this block does
// R01 - ten bit program counter addressing up to 1024 words anywhere
// R02 - four word return stack, always written from the incrementer
// R03 - four test bits captured on each rising edge of the test strobe
// R04 - next address from stack, incrementer, branch or multiway source
// R05 - program counter loads the selected next address every rising clock
// R06 - incrementer always offers program counter plus one
// R07 - outputs show counter, or selector output directly in pipeline mode
// R08 - pipeline select low means non-pipeline, high means pipeline
// R09 - master clear zeroes counter and address output, forcing non-pipeline view
// R10 - four route branches load the full branch address
// R11 - multiway uses branch bits nine to three plus three multiway bits
// R12 - call loads branch address and pushes counter plus one
// R13 - branch-if-set jumps when tested bit high, else steps
// R14 - branch-if-clear jumps when tested bit low, else steps
// R15 - return takes the stack word at read pointer and pops
// R16 - sequential next loads counter plus one
// R17 - non-pipeline outputs stay steady a whole clock cycle
// R18 - system should latch control memory output in pipeline mode
// R19 - route code low except route branches one to three
// R20 - suppress low only for sequential next and return
// R21 - call writes stack this cycle, pointer advances at the edge
// R22 - pointer top bit blocks writes once four levels are held
// R23 - master clear also empties stack; test bits keep their value, zero after presetn, until strobe

module microprogram_sequencer
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`APB_AW-1:0]    paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  pipeline_select,
  input  wire logic                  master_clear_n,
  input  wire logic                  test_strobe,
  input  wire logic [`TEST_W-1:0]    test_in,
  input  wire logic [`ADDR_W-1:0]    branch_target_in,
  input  wire logic [`MW_W-1:0]      multiway_in,
  input  wire logic [`OP_W-1:0]      op_code_in,
  output logic      [`ADDR_W-1:0]    next_address_out,
  output logic      [`ROUTE_W-1:0]   route_code_out,
  output logic                       suppress_out
);

  // --------------------------------------------------------------------------
  // op decode
  // --------------------------------------------------------------------------
  function automatic seq_pkg::op_decode_t decode_op
  (
    input logic [`OP_W-1:0]   op,
    input logic [`TEST_W-1:0] tst
  );
    seq_pkg::op_decode_t d;
    logic                tbit;
    d          = '0;
    d.src      = seq_pkg::src_incr;
    d.suppress = 1'b1;                                          // [R20]
    tbit       = tst[op[`STACK_AW-1:0]];
    case (op[`OP_GROUP_HI:`OP_GROUP_LO])
      `OP_GROUP_ROUTE:
      begin
        d.src   = seq_pkg::src_branch;                          // [R10]
        d.route = op[`ROUTE_W-1:0];                             // [R19]
      end
      `OP_GROUP_SET:
      begin
        d.src = tbit ? seq_pkg::src_branch : seq_pkg::src_incr; // [R13]
      end
      `OP_GROUP_CLEAR:
      begin
        d.src = tbit ? seq_pkg::src_incr : seq_pkg::src_branch; // [R14]
      end
      default:
      begin
        case (op)
          `OP_RETURN:
          begin
            d.src      = seq_pkg::src_stack;                    // [R15]
            d.pop      = 1'b1;
            d.suppress = 1'b0;                                  // [R20]
          end
          `OP_CALL:
          begin
            d.src  = seq_pkg::src_branch;                       // [R12]
            d.push = 1'b1;
          end
          `OP_FETCH:
          begin
            d.src      = seq_pkg::src_incr;                     // [R16]
            d.suppress = 1'b0;                                  // [R20]
          end
          `OP_MULTIWAY:
          begin
            d.src = seq_pkg::src_multiway;                      // [R11]
          end
          default:
          begin
            d.src = seq_pkg::src_incr;
          end
        endcase
      end
    endcase
    return d;
  endfunction : decode_op

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [`ADDR_W-1:0]   program_counter_r;
  logic [`ADDR_W-1:0]   program_counter_nxt;
  logic [`SP_W-1:0]     stack_pointer_r;
  logic [`SP_W-1:0]     stack_pointer_nxt;
  logic [`TEST_W-1:0]   test_r;
  logic [`TEST_W-1:0]   test_nxt;
  logic                 strobe_d_r;
  logic                 soft_clear_r;
  logic                 soft_clear_nxt;
  logic [31:0]          prdata_r;
  logic [31:0]          prdata_nxt;
  logic                 pready_r;
  logic                 pready_nxt;
  logic                 pslverr_r;
  logic                 pslverr_nxt;

  seq_pkg::op_decode_t  dec;
  seq_pkg::stack_req_t  stack_req;
  logic [`ADDR_W-1:0]   incr;
  logic [`ADDR_W-1:0]   stack_word;
  logic [`ADDR_W-1:0]   selected;
  logic                 clear_active;
  logic                 stack_full;
  logic                 apb_access;
  logic                 addr_ctrl;
  logic                 addr_status;

  // --------------------------------------------------------------------------
  // datapath
  // --------------------------------------------------------------------------
  assign dec          = decode_op(op_code_in, test_r);
  assign incr         = program_counter_r + `ADDR_ONE;              // [R06]
  assign clear_active = !master_clear_n || soft_clear_r;
  assign stack_full   = stack_pointer_r[`SP_FULL_BIT];              // [R22]

  always_comb
  begin
    case (dec.src)                                                  // [R04]
      seq_pkg::src_stack:
      begin
        selected = stack_word;
      end
      seq_pkg::src_branch:
      begin
        selected = branch_target_in;
      end
      seq_pkg::src_multiway:
      begin
        selected = {branch_target_in[`ADDR_W-1:`MW_W], multiway_in};
      end
      default:
      begin
        selected = incr;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // sequencer next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    program_counter_nxt = selected;                                 // [R05] [R01]
    stack_pointer_nxt   = stack_pointer_r;
    stack_req.we        = dec.push && !stack_full && !clear_active; // [R22] [R02]
    stack_req.waddr     = stack_pointer_nxt_waddr(stack_pointer_r);
    stack_req.wdata     = incr;                                     // [R02]
    if (dec.push && !stack_full)
    begin
      stack_pointer_nxt = stack_pointer_r + `SP_ONE;                // [R21]
    end
    else if (dec.pop && (stack_pointer_r != `SP_EMPTY))
    begin
      stack_pointer_nxt = stack_pointer_r - `SP_ONE;                // [R15]
    end
    if (clear_active)
    begin
      program_counter_nxt = `ADDR_ZERO;                             // [R09]
      stack_pointer_nxt   = `SP_EMPTY;                              // [R23]
    end
    stack_req.raddr = stack_pointer_nxt[`STACK_AW-1:0];
  end

  function automatic logic [`STACK_AW-1:0] stack_pointer_nxt_waddr
  (
    input logic [`SP_W-1:0] sp
  );
    logic [`SP_W-1:0] up;
    up = sp + `SP_ONE;
    return up[`STACK_AW-1:0];
  endfunction : stack_pointer_nxt_waddr

  // test register, edge of the strobe sampled on pclk
  generate
    for (genvar i = 0; i < `TEST_W; i++)
    begin : g_test
      always_comb
      begin
        test_nxt[i] = (test_strobe && !strobe_d_r) ? test_in[i] : test_r[i]; // [R03]
      end
    end
  endgenerate

  return_stack_mem u_stack
  (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (stack_req),
    .rdata   (stack_word)
  );

  // --------------------------------------------------------------------------
  // apb slave
  // --------------------------------------------------------------------------
  assign apb_access  = psel && penable && !pready_r;
  assign addr_ctrl   = (paddr == `REG_CTRL);
  assign addr_status = (paddr == `REG_STATUS);

  always_comb
  begin
    pready_nxt     = apb_access;
    pslverr_nxt    = 1'b0;
    prdata_nxt     = `DATA_ZERO;
    soft_clear_nxt = soft_clear_r;
    if (apb_access)
    begin
      if (addr_ctrl)
      begin
        if (pwrite)
        begin
          soft_clear_nxt = pwdata[`CTRL_SOFT_CLEAR];
        end
        else
        begin
          prdata_nxt[`CTRL_SOFT_CLEAR] = soft_clear_r;
        end
      end
      else if (addr_status)
      begin
        if (!pwrite)
        begin
          prdata_nxt[`ST_PC_HI:`ST_PC_LO]     = program_counter_r;
          prdata_nxt[`ST_SP_HI:`ST_SP_LO]     = stack_pointer_r;
          prdata_nxt[`ST_TEST_HI:`ST_TEST_LO] = test_r;
          prdata_nxt[`ST_PIPE]                = pipeline_select && master_clear_n;
          prdata_nxt[`ST_CLEAR]               = clear_active;
        end
      end
      else
      begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      program_counter_r <= `ADDR_ZERO;
      stack_pointer_r   <= `SP_EMPTY;
      test_r            <= '0;
      strobe_d_r        <= 1'b0;
      soft_clear_r      <= 1'b0;
      prdata_r          <= `DATA_ZERO;
      pready_r          <= 1'b0;
      pslverr_r         <= 1'b0;
    end
    else
    begin
      program_counter_r <= program_counter_nxt;
      stack_pointer_r   <= stack_pointer_nxt;
      test_r            <= test_nxt;
      strobe_d_r        <= test_strobe;
      soft_clear_r      <= soft_clear_nxt;
      prdata_r          <= prdata_nxt;
      pready_r          <= pready_nxt;
      pslverr_r         <= pslverr_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  // pipeline view is combinational by nature; the system latches it [R18]
  always_comb
  begin
    if (!master_clear_n)
    begin
      next_address_out = `ADDR_ZERO;                                // [R09]
    end
    else if (pipeline_select)
    begin
      next_address_out = soft_clear_r ? `ADDR_ZERO : selected;      // [R07] [R08]
    end
    else
    begin
      next_address_out = program_counter_r;                         // [R07] [R17]
    end
  end

  assign route_code_out = dec.route;                                // [R19]
  assign suppress_out   = dec.suppress;                             // [R20]
  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;

endmodule : microprogram_sequencer

// ===== include/seq_defines.svh
// named constants of the microprogram sequencer: widths, opcodes, register map
// assumes inclusion by bare name from the package and the design files
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// widths and stack geometry
// ----------------------------------------------------------------------------
`define ADDR_W          10
`define ADDR_ZERO       10'h000
`define ADDR_ONE        10'h001
`define STACK_DEPTH     4
`define STACK_AW        2
`define SP_W            3
`define SP_EMPTY        3'h0
`define SP_ONE          3'h1
`define SP_FULL_BIT     2
`define TEST_W          4
`define MW_W            3
`define OP_W            4
`define ROUTE_W         2

// ----------------------------------------------------------------------------
// op codes, op_code_in[3:0]
// ----------------------------------------------------------------------------
`define OP_RETURN       4'h0
`define OP_CALL         4'h1
`define OP_FETCH        4'h2
`define OP_MULTIWAY     4'h3
`define OP_ROUTE_0      4'h4
`define OP_ROUTE_3      4'h7
`define OP_BR_CLEAR_0   4'h8
`define OP_BR_CLEAR_3   4'hb
`define OP_BR_SET_0     4'hc
`define OP_BR_SET_3     4'hf
`define OP_GROUP_HI     3
`define OP_GROUP_LO     2
`define OP_GROUP_ROUTE  2'h1
`define OP_GROUP_CLEAR  2'h2
`define OP_GROUP_SET    2'h3

// ----------------------------------------------------------------------------
// apb register map, byte addresses
// ----------------------------------------------------------------------------
`define APB_AW          8
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define CTRL_SOFT_CLEAR 0
`define ST_PC_LO        0
`define ST_PC_HI        9
`define ST_SP_LO        12
`define ST_SP_HI        14
`define ST_TEST_LO      16
`define ST_TEST_HI      19
`define ST_PIPE         20
`define ST_CLEAR        21
`define DATA_ZERO       32'h0000_0000

`endif

// ===== include/seq_pkg.sv
// types shared by the microprogram sequencer files
// assumes seq_defines.svh on the include path
`include "seq_defines.svh"

package seq_pkg;

  // --------------------------------------------------------------------------
  // next-address source and decoded operation
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    src_stack,
    src_incr,
    src_branch,
    src_multiway
  } addr_src_t;

  typedef struct packed {
    addr_src_t             src;
    logic                  push;
    logic                  pop;
    logic [`ROUTE_W-1:0]   route;
    logic                  suppress;
  } op_decode_t;

  typedef struct packed {
    logic                  we;
    logic [`STACK_AW-1:0]  waddr;
    logic [`ADDR_W-1:0]    wdata;
    logic [`STACK_AW-1:0]  raddr;
  } stack_req_t;

endpackage : seq_pkg

// ===== rtl/return_stack_mem.sv
// four word return-address memory with registered read data
// assumes one clock; read address is the pointer value for the next cycle
`timescale 1ns/1ns
`include "seq_defines.svh"

module return_stack_mem
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire seq_pkg::stack_req_t    req,
  output logic        [`ADDR_W-1:0]   rdata
);

  logic [`ADDR_W-1:0] mem_r [`STACK_DEPTH];
  logic [`ADDR_W-1:0] rdata_r;
  logic [`ADDR_W-1:0] rdata_nxt;

  // --------------------------------------------------------------------------
  // read path, a word written this cycle is passed through
  // --------------------------------------------------------------------------
  always_comb
  begin
    if (req.we && (req.waddr == req.raddr))
    begin
      rdata_nxt = req.wdata;
    end
    else
    begin
      rdata_nxt = mem_r[req.raddr];
    end
  end

  always_ff @(posedge pclk)
  begin
    if (req.we)
    begin
      mem_r[req.waddr] <= req.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_r <= `ADDR_ZERO;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

endmodule : return_stack_mem

// ===== test/seq_chk.sv
// checker of the sequencer's port relations
// assumes binding into microprogram_sequencer, one clock domain
`timescale 1ns/1ns
`include "seq_defines.svh"

module seq_chk
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 pipeline_select,
  input wire logic                 master_clear_n,
  input wire logic [`ADDR_W-1:0]   branch_target_in,
  input wire logic [`MW_W-1:0]     multiway_in,
  input wire logic [`OP_W-1:0]     op_code_in,
  input wire logic [`ADDR_W-1:0]   next_address_out,
  input wire logic [`ROUTE_W-1:0]  route_code_out,
  input wire logic                 suppress_out
);
  // ----------
  // helpers
  // ----------
  logic               np;
  logic [`ADDR_W-1:0] mw_addr;
  assign np = master_clear_n && !pipeline_select;
  assign mw_addr = {branch_target_in[9:3], multiway_in};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------
  // assertions
  // ----------
  AST_ROUTE_CODE: assert property (route_code_out == (op_code_in[3:2] == 2'h1 ? op_code_in[1:0] : 2'h0))
    else $error("route code wrong");
  AST_SUPPRESS: assert property (suppress_out == !(op_code_in == `OP_RETURN || op_code_in == `OP_FETCH))
    else $error("suppress wrong");
  AST_CLEAR_OUT: assert property (!master_clear_n |-> next_address_out == `ADDR_ZERO)
    else $error("address not zero under clear");
  AST_FETCH_STEP: assert property (np && op_code_in == `OP_FETCH ##1 np
    |-> next_address_out == $past(next_address_out) + `ADDR_ONE)
    else $error("fetch did not step");
  AST_ROUTE_LOAD: assert property (np && op_code_in[3:2] == 2'h1 ##1 np
    |-> next_address_out == $past(branch_target_in))
    else $error("route branch target wrong");
  AST_MULTIWAY: assert property (np && op_code_in == `OP_MULTIWAY ##1 np
    |-> next_address_out == $past(mw_addr))
    else $error("multiway target wrong");
  AST_PIPE_VIEW: assert property (master_clear_n && pipeline_select && op_code_in[3:2] == 2'h1
    |-> next_address_out == branch_target_in)
    else $error("pipeline view wrong");
  AST_CALL_RETURN: assert property (np && op_code_in == `OP_CALL ##1 np && op_code_in == `OP_RETURN ##1 np
    |-> next_address_out == $past(next_address_out, 2) + `ADDR_ONE)
    else $error("return address wrong");
endmodule : seq_chk

bind microprogram_sequencer seq_chk u_chk (.pclk, .presetn, .pipeline_select, .master_clear_n,
  .branch_target_in, .multiway_in, .op_code_in, .next_address_out, .route_code_out, .suppress_out);

// ===== test/ureg_model.sv
// external microinstruction register beside the control memory
// assumes the address bus of the sequencer and its clock
`timescale 1ns/1ns
`include "seq_defines.svh"

module ureg_model
(
  input  wire logic               pclk,
  input  wire logic [`ADDR_W-1:0] addr_in,
  output logic      [`ADDR_W-1:0] addr_q
);
  // holds the fetched word a full cycle when addresses run ahead
  always_ff @(posedge pclk)
  begin
    addr_q <= addr_in;
  end
endmodule : ureg_model

// ===== test/microprogram_sequencer_tb.sv
// self-checking bench of the microprogram sequencer
// assumes seq_chk bound in, ureg_model as the far side
`timescale 1ns/1ns
`include "seq_defines.svh"

module microprogram_sequencer_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        pipeline_select, master_clear_n, test_strobe, suppress_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  test_in, op_code_in, o, t, tst;
  logic [9:0]  branch_target_in, next_address_out, ureg_q, b, pc, prev_out;
  logic [2:0]  multiway_in, m, sp;
  logic [1:0]  route_code_out;
  logic        s, pl, mc, ps;
  logic [9:0]  stk [4];
  logic [22:0] aq [$];
  logic [33:0] rq [$];
  logic [22:0] e;
  logic [33:0] r;
  int          failures, checks_done, i, k;

  microprogram_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pipeline_select, .master_clear_n, .test_strobe, .test_in, .branch_target_in,
    .multiway_in, .op_code_in, .next_address_out, .route_code_out, .suppress_out);
  ureg_model u_ureg (.pclk, .addr_in(next_address_out), .addr_q(ureg_q));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ----------
  // shared tasks
  // ----------
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp)
      begin
        failures++;
        $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
    end
  endtask : check

  // drives one sequencer cycle and notes what the outputs must show in it
  task automatic cyc;
    logic [9:0] nx;
    logic       hit;
    begin
      pipeline_select <= pl;
      master_clear_n <= mc;
      op_code_in <= o;
      branch_target_in <= b;
      multiway_in <= m;
      test_in <= t;
      test_strobe <= s;
      hit = tst[o[1:0]] ^ ~o[2];
      case (o)
        `OP_RETURN: nx = stk[sp[1:0]];
        `OP_FETCH: nx = pc + 10'h001;
        `OP_MULTIWAY: nx = {b[9:3], m};
        default: nx = (o[3] && !hit) ? pc + 10'h001 : b;
      endcase
      e = {(!mc ? 10'h000 : (pl ? nx : pc)), prev_out, (o[3:2] == 2'h1 ? o[1:0] : 2'h0),
           !(o == `OP_RETURN || o == `OP_FETCH)};
      aq.push_back(e);
      prev_out = e[22:13];
      @(posedge pclk);
      if (!mc)
      begin
        pc = 10'h000;
        sp = 3'h0;
      end
      else
      begin
        if (o == `OP_CALL && !sp[2])
        begin
          stk[sp[1:0] + 2'h1] = pc + 10'h001;
          sp = sp + 3'h1;
        end
        if (o == `OP_RETURN && sp != 3'h0)
          sp = sp - 3'h1;
        pc = nx;
      end
      if (s && !ps)
        tst = t;
      ps = s;
    end
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
    int n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      rq.push_back(x);
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
        n++;
        if (n > 20)
        begin
          failures++;
          summarize();
        end
        @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb

  function automatic logic [31:0] st(input logic c);
    return {10'h000, c, 1'b0, tst, 1'b0, sp, 2'b00, pc};
  endfunction : st

  task automatic summarize;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask : summarize
  // ----------
  // result watchers
  // ----------
  always @(negedge pclk)
  begin
    if (aq.size() > 0)
    begin
      e = aq.pop_front();
      check("address", 32'(next_address_out), 32'(e[22:13]));
      check("ureg", 32'(ureg_q), 32'(e[12:3]));
      check("route", 32'(route_code_out), 32'(e[2:1]));
      check("suppress", 32'(suppress_out), 32'(e[0]));
    end
  end

  always @(posedge pclk)
  begin
    if (pready === 1'b1)
    begin
      r = rq.pop_front();
      check("pslverr", 32'(pslverr), 32'(r[32]));
      if (r[33])
        check("prdata", prdata, r[31:0]);
    end
  end
  // ----------
  // main sequence
  // ----------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, test_strobe, test_in} = '0;
    {pipeline_select, op_code_in, branch_target_in, multiway_in} = '0;
    {o, t, b, m, s, pl, ps, pc, sp, tst, prev_out, failures, checks_done} = '0;
    master_clear_n = 1'b1;
    mc = 1'b1;
    presetn = 1'b0;
    void'($urandom(32'h74db));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      o = `OP_CALL;
      b = 10'(i * 37 + 5);
      cyc();
    end
    o = `OP_FETCH;
    cyc();
    for (i = 0; i < 6; i++)
    begin
      o = (i == 5) ? `OP_CALL : `OP_RETURN;
      cyc();
    end
    o = `OP_RETURN;
    cyc();
    for (k = 0; k < 4; k++)
    begin
      pl = k[1];
      t = k[0] ? 4'h5 : 4'ha;
      s = 1'b1;
      cyc();
      s = 1'b0;
      for (i = 0; i < 16; i++)
      begin
        o = 4'(i);
        b = 10'($urandom);
        m = 3'($urandom);
        cyc();
      end
    end
    for (i = 0; i < 300; i++)
    begin
      {o, b, m, t, s, pl} = 23'($urandom);
      mc = 4'($urandom) != 4'h0;
      if (o == `OP_CALL && sp > 3'h2)
        o = `OP_FETCH;
      cyc();
    end
    {o, b, s, pl, mc} = {`OP_ROUTE_0, 10'h000, 1'b0, 1'b0, 1'b1};
    repeat (2) cyc();
    sp = 3'h0;
    apb(1'b1, `REG_CTRL, 32'h1, 34'h0);
    apb(1'b0, `REG_STATUS, 32'h0, {2'b10, st(1'b1)});
    apb(1'b0, `REG_CTRL, 32'h0, {2'b10, 32'h1});
    apb(1'b1, `REG_STATUS, 32'hffff_ffff, 34'h0);
    apb(1'b1, `REG_CTRL, 32'h0, 34'h0);
    apb(1'b0, `REG_STATUS, 32'h0, {2'b10, st(1'b0)});
    apb(1'b0, 8'h08, 32'h0, {2'b11, 32'h0});
    for (i = 0; i < 40; i++)
    begin
      {o, b, m, t, s, pl} = 23'($urandom);
      if (o == `OP_CALL && sp > 3'h2)
        o = `OP_FETCH;
      cyc();
    end
    repeat (2) @(posedge pclk);
    summarize();
  end
endmodule : microprogram_sequencer_tb
